// ---- rtl/vxi_backplane_slave_port.sv ----
// Backplane slave port of a single-channel digitizer module
// Assumes an AXI4-Lite master, a byte-wide local-bus sink and shared trigger lines
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "bp_defs.svh"
module vxi_backplane_slave_port #(
  parameter int MEM_ADDR_W = 4,
  parameter logic [7:0] CLK_HALF = `CLK_HALF_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [3:0] grant_in,
  output logic [3:0] grant_out,
  output logic [3:0] bus_request,
  output logic irq,
  output logic [2:0] irq_level,
  input wire logic sysreset_n,
  output logic reload_config,
  output logic resync,
  input wire logic sync_line_i,
  output logic sync_line_o,
  output logic sync_line_oe,
  input wire logic clk_line_i,
  output logic clk_line_o,
  output logic clk_line_oe,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [63:0] sample_data,
  input wire logic adc_overload,
  input wire logic adc_error,
  output logic [7:0] lbus_data,
  output logic lbus_valid,
  input wire logic lbus_ready,
  output logic access_led
);

  typedef struct packed {
    logic [2:0] prio;
    logic port_lbus;
    logic [3:0] meas;
    logic [15:0] block_len;
    logic [`IRQ_W-1:0] irq_status;
    logic [`IRQ_W-1:0] irq_enable;
    bp_pkg::meas_state_t mstate;
    logic [15:0] word_cnt;
    logic ovl_seen;
    logic err_seen;
    logic clk_prev;
    logic sync_prev;
    logic sync_out;
    logic sync_oe;
    logic [7:0] div_cnt;
    logic clk_gen;
    logic soft_rst;
    logic hw_prev;
    logic reload;
    logic resync;
    logic aw_got;
    logic w_got;
    logic [15:0] aw_addr;
    logic [15:0] w_data;
    logic [1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic [1:0] word_sel;
    logic lb_valid;
    logic [2:0] lb_byte;
    logic [63:0] lb_word;
    logic [7:0] lb_data;
  } port_state_t;

  port_state_t s;
  port_state_t next_s;
  logic [2:0] pin_q;
  logic hw_rst;
  logic clk_rise;
  logic clk_fall;
  logic sync_evt;
  logic soft_clear;
  logic mem_push;
  logic mem_pop;
  logic mem_wready;
  logic mem_rvalid;
  logic [63:0] mem_wdata;
  logic [63:0] mem_rdata;
  logic [`IRQ_W-1:0] events;

  // =====================================================================
  // Helper functions
  // Address decode over the low 16 bits only
  function automatic logic is_mapped(input logic [15:0] addr);
    case (addr)
      `REG_CONTROL, `REG_STATUS, `REG_IRQ_STATUS, `REG_IRQ_CLEAR,
      `REG_IRQ_ENABLE, `REG_PORT_SEL, `REG_MEAS_CTRL, `REG_DATA_OUT,
      `REG_BLOCK_LEN: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // Byte-lane merge of a 16-bit write
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] val,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? val[15:8] : old[15:8], strb[0] ? val[7:0] : old[7:0]};
  endfunction : merge16

  // One byte out of a 64-bit word
  function automatic logic [7:0] byte_of(input logic [63:0] word, input logic [2:0] idx);
    byte_of = word[{idx, 3'h0} +: 8];
  endfunction : byte_of

  // =====================================================================
  // Pin synchronisers: system reset, sample clock line, sync line
  pin_sync #(
    .W(3),
    .RESET_VAL(`PIN_RESET_VAL)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din({sync_line_i, clk_line_i, sysreset_n}),
    .q(pin_q)
  );

  // Output memory holding acquired words
  out_mem #(
    .WIDTH(64),
    .ADDR_W(MEM_ADDR_W)
  ) u_out_mem (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(soft_clear),
    .wr_valid(mem_push),
    .wr_ready(mem_wready),
    .wr_data(mem_wdata),
    .rd_pop(mem_pop),
    .rd_valid(mem_rvalid),
    .rd_data(mem_rdata)
  );

  // Sample clock edges and rising sync transitions seen on the line
  assign hw_rst = ~pin_q[0];
  assign clk_rise = pin_q[1] & ~s.clk_prev;
  assign clk_fall = ~pin_q[1] & s.clk_prev;
  assign sync_evt = clk_rise & pin_q[2] & ~s.sync_prev;
  assign soft_clear = s.soft_rst | hw_rst;

  // =====================================================================
  // Next-state logic
  always_comb
  begin
    next_s = s;
    next_s.soft_rst = 1'b0;
    next_s.resync = 1'b0;
    next_s.clk_prev = pin_q[1];
    next_s.hw_prev = hw_rst;
    next_s.reload = hw_rst & ~s.hw_prev;
    mem_push = 1'b0;
    mem_pop = 1'b0;
    mem_wdata = sample_data;
    events = '0;

    // Register bus: capture address and data in either order
    if (awvalid & awready)
    begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = awaddr[15:0];
    end
    if (wvalid & wready)
    begin
      next_s.w_got = 1'b1;
      next_s.w_data = wdata[15:0];
      next_s.w_strb = wstrb[1:0];
    end
    if (s.bvalid & bready)
      next_s.bvalid = 1'b0;

    // Register writes once both halves are held
    if (s.aw_got & s.w_got & ~s.bvalid)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = is_mapped(s.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      case (s.aw_addr)
        `REG_CONTROL:
        begin
          if (s.w_strb[0])
          begin
            next_s.soft_rst = s.w_data[`CTRL_SOFT_RESET];
            next_s.prio = s.w_data[`CTRL_PRIO_MSB:`CTRL_PRIO_LSB];
          end
        end
        `REG_IRQ_CLEAR:
          next_s.irq_status = s.irq_status & ~(s.w_data[`IRQ_W-1:0] & {`IRQ_W{s.w_strb[0]}});
        `REG_IRQ_ENABLE:
          next_s.irq_enable = (`IRQ_W)'(merge16(16'(s.irq_enable), s.w_data, s.w_strb));
        `REG_PORT_SEL:
          if (s.w_strb[0])
            next_s.port_lbus = s.w_data[`PORT_SEL_LBUS];
        `REG_MEAS_CTRL:
          next_s.meas = 4'(merge16(16'(s.meas), s.w_data, s.w_strb));
        `REG_BLOCK_LEN:
          next_s.block_len = merge16(s.block_len, s.w_data, s.w_strb);
        default:
          next_s.bresp = next_s.bresp;
      endcase
    end

    // Register reads; data word advances only on the VME path
    if (s.rvalid & rready)
      next_s.rvalid = 1'b0;
    if (arvalid & arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = is_mapped(araddr[15:0]) ? `RESP_OKAY : `RESP_SLVERR;
      next_s.rdata = 16'h0000;
      case (araddr[15:0])
        `REG_CONTROL: next_s.rdata = {12'h000, s.prio, 1'b0};
        `REG_STATUS: next_s.rdata = {8'h00, s.ovl_seen, s.err_seen, mem_rvalid, s.mstate};
        `REG_IRQ_STATUS: next_s.rdata = 16'(s.irq_status);
        `REG_IRQ_ENABLE: next_s.rdata = 16'(s.irq_enable);
        `REG_PORT_SEL: next_s.rdata = {15'h0000, s.port_lbus};
        `REG_MEAS_CTRL: next_s.rdata = {12'h000, s.meas};
        `REG_BLOCK_LEN: next_s.rdata = s.block_len;
        `REG_DATA_OUT:
        begin
          if (~s.port_lbus & mem_rvalid)
          begin
            next_s.rdata = mem_rdata[{s.word_sel, 4'h0} +: 16];
            next_s.word_sel = s.word_sel + 2'h1;
            mem_pop = s.word_sel == 2'h3;
          end
        end
        default: next_s.rdata = 16'h0000;
      endcase
    end

    // Local bus: load a word, then send eight bytes low first
    if (s.port_lbus & mem_rvalid & ~s.lb_valid)
    begin
      mem_pop = 1'b1;
      next_s.lb_word = mem_rdata;
      next_s.lb_valid = 1'b1;
      next_s.lb_byte = 3'h0;
      next_s.lb_data = byte_of(mem_rdata, 3'h0);
    end
    else if (s.lb_valid & lbus_ready)
    begin
      if (s.lb_byte == 3'h7)
        next_s.lb_valid = 1'b0;
      else
      begin
        next_s.lb_byte = s.lb_byte + 3'h1;
        next_s.lb_data = byte_of(s.lb_word, s.lb_byte + 3'h1);
      end
    end

    // Sample clock generator for the clock master
    if (s.div_cnt >= CLK_HALF - 8'h01)
    begin
      next_s.div_cnt = 8'h00;
      next_s.clk_gen = ~s.clk_gen;
    end
    else
      next_s.div_cnt = s.div_cnt + 8'h01;

    // Software-driven sync changes only on a falling sample clock
    if (clk_fall)
    begin
      next_s.sync_out = s.meas[`MEAS_SYNC_VALUE];
      next_s.sync_oe = s.meas[`MEAS_SYNC_DRIVE];
    end
    if (clk_rise)
      next_s.sync_prev = pin_q[2];

    // Measurement loop; sync meaning depends on the state
    if (s.mstate == bp_pkg::MS_CAPTURE)
    begin
      next_s.ovl_seen = s.ovl_seen | adc_overload;
      next_s.err_seen = s.err_seen | adc_error;
      events[`IRQ_OVERLOAD] = adc_overload;
      events[`IRQ_ADC_ERROR] = adc_error;
    end
    case (s.mstate)
      bp_pkg::MS_IDLE:
        if (sync_evt)
        begin
          next_s.resync = 1'b1;
          next_s.mstate = bp_pkg::MS_SYNCED;
        end
      bp_pkg::MS_SYNCED:
        if (sync_evt)
          next_s.mstate = bp_pkg::MS_ARMED;
      bp_pkg::MS_ARMED:
        if (sync_evt)
        begin
          next_s.mstate = bp_pkg::MS_CAPTURE;
          next_s.word_cnt = 16'h0000;
          next_s.ovl_seen = 1'b0;
          next_s.err_seen = 1'b0;
          events[`IRQ_TRIGGER] = 1'b1;
        end
      bp_pkg::MS_CAPTURE:
      begin
        mem_push = sample_valid;
        if (sample_valid & mem_wready)
        begin
          next_s.word_cnt = s.word_cnt + 16'h0001;
          if (s.word_cnt + 16'h0001 >= s.block_len)
          begin
            if (s.meas[`MEAS_APPEND])
              next_s.mstate = bp_pkg::MS_APPEND;
            else
            begin
              next_s.mstate = bp_pkg::MS_IDLE;
              events[`IRQ_BLOCK_DONE] = 1'b1;
            end
          end
        end
      end
      bp_pkg::MS_APPEND:
      begin
        mem_push = 1'b1;
        mem_wdata = {`STATUS_TAG, 46'h0, s.err_seen, s.ovl_seen};
        if (mem_wready)
        begin
          next_s.mstate = bp_pkg::MS_IDLE;
          events[`IRQ_BLOCK_DONE] = 1'b1;
        end
      end
      default: next_s.mstate = bp_pkg::MS_IDLE;
    endcase

    // Sticky status: a new event wins over a clear in the same cycle
    next_s.irq_status = next_s.irq_status | events;

    // Soft and hardware reset; hardware also clears control
    if (soft_clear)
    begin
      next_s.mstate = bp_pkg::MS_IDLE;
      next_s.word_cnt = 16'h0000;
      next_s.ovl_seen = 1'b0;
      next_s.err_seen = 1'b0;
      next_s.irq_status = '0;
      next_s.word_sel = 2'h0;
      next_s.lb_valid = 1'b0;
      next_s.lb_byte = 3'h0;
      mem_push = 1'b0;
      mem_pop = 1'b0;
      if (hw_rst)
        next_s.prio = 3'h0;
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s <= '0;
      s.block_len <= `BLOCK_LEN_RESET;
      s.mstate <= bp_pkg::MS_IDLE;
    end
    else
      s <= next_s;
  end

  // =====================================================================
  // Outputs
  // Register bus handshakes and answers
  assign awready = ~s.aw_got & ~s.bvalid;
  assign wready = ~s.w_got & ~s.bvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = ~s.rvalid;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = {16'h0000, s.rdata};

  // Arbitration pass-through, never a requester
  assign grant_out = grant_in;
  assign bus_request = 4'h0;

  // Interrupt and its level
  assign irq = |(s.irq_status & s.irq_enable);
  assign irq_level = irq ? s.prio : 3'h0;

  // Trigger lines: clock only as master, sync as programmed
  assign clk_line_o = s.clk_gen;
  assign clk_line_oe = s.meas[`MEAS_CLK_MASTER];
  assign sync_line_o = s.sync_out;
  assign sync_line_oe = s.sync_oe;
  assign reload_config = s.reload;
  assign resync = s.resync;

  // Data paths
  assign sample_ready = (s.mstate == bp_pkg::MS_CAPTURE) & mem_wready & ~soft_clear;
  assign lbus_data = s.lb_data;
  assign lbus_valid = s.lb_valid;

  // Access indicator while a mapped address is presented, a write address is held, or an answer is pending
  assign access_led = (awvalid & is_mapped(awaddr[15:0])) | (arvalid & is_mapped(araddr[15:0]))
                      | s.aw_got | s.bvalid | s.rvalid;

endmodule : vxi_backplane_slave_port

// ---- rtl/bp_defs.svh ----
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from every file that needs them
`ifndef BP_DEFS_SVH
`define BP_DEFS_SVH

// =====================================================================
// Register byte offsets inside the 16-bit window
`define REG_CONTROL 16'h0000
`define REG_STATUS 16'h0004
`define REG_IRQ_STATUS 16'h0008
`define REG_IRQ_CLEAR 16'h000C
`define REG_IRQ_ENABLE 16'h0010
`define REG_PORT_SEL 16'h0014
`define REG_MEAS_CTRL 16'h0018
`define REG_DATA_OUT 16'h001C
`define REG_BLOCK_LEN 16'h0020

// =====================================================================
// Field positions
`define CTRL_SOFT_RESET 0
`define CTRL_PRIO_LSB 1
`define CTRL_PRIO_MSB 3
`define PORT_SEL_LBUS 0
`define MEAS_SYNC_DRIVE 0
`define MEAS_SYNC_VALUE 1
`define MEAS_CLK_MASTER 2
`define MEAS_APPEND 3
`define IRQ_BLOCK_DONE 0
`define IRQ_OVERLOAD 1
`define IRQ_ADC_ERROR 2
`define IRQ_TRIGGER 3
`define IRQ_W 4

// =====================================================================
// Reset values, codes and timing counts
`define BLOCK_LEN_RESET 16'h0100
`define STATUS_TAG 16'h5A5A
`define CLK_HALF_CYCLES 8'h04
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define PIN_RESET_VAL 3'h1

`endif

// ---- rtl/bp_pkg.sv ----
// Types shared by the backplane slave port files
// Assumes bp_defs.svh supplies the numeric constants
package bp_pkg;

  // Measurement loop states, one-hot
  typedef enum logic [4:0] {
    MS_IDLE = 5'b00001,
    MS_SYNCED = 5'b00010,
    MS_ARMED = 5'b00100,
    MS_CAPTURE = 5'b01000,
    MS_APPEND = 5'b10000
  } meas_state_t;

endpackage : bp_pkg

// ---- rtl/pin_sync.sv ----
// Three-stage synchroniser for backplane pins
// Assumes inputs are asynchronous to clk_sys
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  // =====================================================================
  // Shift chain; output follows once stages two and three agree
  always_comb
  begin
    next_s = s;
    next_s.s1 = din;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < W; i++)
    begin
      if (s.s2[i] == s.s3[i])
        next_s.q[i] = s.s3[i];
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      s <= {4{RESET_VAL}};
    else
      s <= next_s;
  end

  assign q = s.q;

endmodule : pin_sync

// ---- rtl/out_mem.sv ----
// Output sample memory with registered read word
// Assumes one pop per valid word; pop while not valid is ignored
`timescale 1ns/100ps
module out_mem #(
  parameter int WIDTH = 64,
  parameter int ADDR_W = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clear,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_pop,
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data
);

  typedef struct packed {
    logic [ADDR_W-1:0] wptr;
    logic [ADDR_W-1:0] rptr;
    logic [ADDR_W:0] count;
    logic rvalid;
  } mem_state_t;

  mem_state_t s;
  mem_state_t next_s;
  logic [WIDTH-1:0] store [2**ADDR_W];
  logic [WIDTH-1:0] rword;
  logic push;
  logic pop;

  assign wr_ready = s.count != (ADDR_W + 1)'(2**ADDR_W);
  assign push = wr_valid & wr_ready;
  assign pop = rd_pop & s.rvalid;

  // =====================================================================
  // Pointer and fill bookkeeping; valid drops for a cycle after a pop
  always_comb
  begin
    next_s = s;
    if (push)
      next_s.wptr = s.wptr + 1'b1;
    if (pop)
      next_s.rptr = s.rptr + 1'b1;
    next_s.count = s.count + (ADDR_W + 1)'(push) - (ADDR_W + 1)'(pop);
    next_s.rvalid = (s.count != '0) & ~pop;
    if (clear)
      next_s = '0;
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  // Storage array and registered read word
  always_ff @(posedge clk_sys)
  begin
    if (push)
      store[s.wptr] <= wr_data;
    rword <= store[s.rptr];
  end

  assign rd_valid = s.rvalid;
  assign rd_data = rword;

endmodule : out_mem

// ---- testbench/vxi_bp_asserts.sv ----
// Checker on the backplane slave port
// Assumes a bind onto the top module
`timescale 1ns/100ps
module vxi_bp_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic [3:0] grant_in,
  input wire logic [3:0] grant_out,
  input wire logic [3:0] bus_request,
  input wire logic irq,
  input wire logic [2:0] irq_level,
  input wire logic sysreset_n,
  input wire logic reload_config,
  input wire logic [7:0] lbus_data,
  input wire logic lbus_valid,
  input wire logic lbus_ready
);
  // =====
  // Clock and reset
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // =====
  // Properties
  AST_GRANT: assert property (grant_out == grant_in)
    else $error("grant chain not passed through");
  AST_NOREQ: assert property (bus_request == 4'h0)
    else $error("bus request raised");
  AST_LEVEL: assert property (!irq |-> irq_level == 3'h0)
    else $error("level without interrupt");
  AST_RHIGH: assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_RANS: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  AST_RDONE: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer repeated");
  AST_BDONE: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer repeated");
  AST_LHOLD: assert property (lbus_valid && !lbus_ready |=> lbus_valid && $stable(lbus_data))
    else $error("local bus byte dropped");
  AST_RELOAD: assert property ($fell(sysreset_n) |-> ##[2:8] reload_config)
    else $error("no reload after system reset");

  // Main scenarios
  cover property (irq);
  cover property (lbus_valid && !lbus_ready);
  cover property (bvalid && bresp == 2'h2);
  cover property (reload_config);
endmodule : vxi_bp_asserts

// ---- testbench/vxi_peer_model.sv ----
// Peer module on the trigger lines and local-bus sink
// Assumes clk_sys domain; sample clock derived from it
`timescale 1ns/100ps
module vxi_peer_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic [3:0] want,
  output logic clk_line,
  output logic sync_line,
  input wire logic [7:0] lbus_data,
  input wire logic lbus_valid,
  output logic lbus_ready,
  output logic [63:0] word,
  output logic [3:0] nbytes
);
  logic [1:0] div;
  logic [3:0] sent;
  logic [1:0] stall;

  // Sample clock low when idle; sync moves on its falling edge
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      div <= 2'h0;
      clk_line <= 1'b0;
      sync_line <= 1'b0;
      sent <= 4'h0;
    end
    else
    begin
      div <= div + 2'h1;
      if (div == 2'h3 && clk_line)
      begin
        sync_line <= !sync_line && sent != want;
        if (!sync_line && sent != want)
          sent <= sent + 4'h1;
      end
      if (div == 2'h3)
        clk_line <= run && !clk_line;
    end
  end

  // Byte sink refusing one cycle in three
  assign lbus_ready = stall != 2'h0;
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      stall <= 2'h0;
      word <= 64'h0;
      nbytes <= 4'h0;
    end
    else
    begin
      stall <= (stall == 2'h2) ? 2'h0 : stall + 2'h1;
      if (lbus_valid && lbus_ready)
      begin
        word <= {lbus_data, word[63:8]};
        nbytes <= nbytes + 4'h1;
      end
    end
  end
endmodule : vxi_peer_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the backplane slave port
// Assumes the checker and peer model are compiled first
`timescale 1ns/100ps
`include "bp_defs.svh"
module testbench;
  logic clk_sys, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, rv;
  logic [1:0] bresp, rresp, rr;
  logic [3:0] grant_in, grant_out, bus_request, want, pbytes;
  logic irq, sysreset_n, sync_line_i, sync_line_o, sync_line_oe, clk_line_i, clk_line_o, clk_line_oe, led;
  logic [2:0] irq_level;
  logic sample_valid, sample_ready, adc_overload, lbus_valid, lbus_ready, run, peer_clk, peer_sync;
  logic [63:0] sample_data, pword;
  logic [7:0] lbus_data;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;

  // =====
  // Design, peer and shared lines
  vxi_backplane_slave_port u_dut (.clk_sys, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .grant_in, .grant_out, .bus_request, .irq, .irq_level, .sysreset_n, .reload_config(),
    .resync(), .sync_line_i, .sync_line_o, .sync_line_oe, .clk_line_i, .clk_line_o, .clk_line_oe,
    .sample_valid, .sample_ready, .sample_data, .adc_overload, .adc_error(adc_overload), .lbus_data,
    .lbus_valid, .lbus_ready, .access_led(led));
  vxi_peer_model u_peer (.clk_sys, .rst, .run, .want, .clk_line(peer_clk), .sync_line(peer_sync),
    .lbus_data, .lbus_valid, .lbus_ready, .word(pword), .nbytes(pbytes));
  assign clk_line_i = clk_line_oe ? clk_line_o : peer_clk;
  assign sync_line_i = sync_line_oe ? sync_line_o : peer_sync;

  // =====
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic ta, tw, b;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clk_sys);
      ta = awready;
      tw = wready;
      b = bvalid;
      rr = bresp;
      @(posedge clk_sys);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
    end while (!b);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a);
    logic ta, b;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge clk_sys);
      ta = arready;
      b = rvalid;
      rv = rdata;
      rr = rresp;
      if (b) chk("led", {31'h0, led}, 32'h1);
      @(posedge clk_sys);
      if (ta)
        arvalid <= 1'b0;
    end while (!b);
    rready <= 1'b0;
  endtask : rd

  task automatic wait_st(input logic [4:0] st);
    rv = 32'h0;
    for (int i = 0; i < 40 && rv[4:0] !== st; i++)
      rd(`REG_STATUS);
    chk("state", {27'h0, rv[4:0]}, {27'h0, st});
  endtask : wait_st

  task automatic push(input logic [63:0] d, input logic ovl);
    logic t;
    @(posedge clk_sys);
    sample_data <= d;
    sample_valid <= 1'b1;
    adc_overload <= ovl;
    do
    begin
      @(negedge clk_sys);
      t = sample_ready;
      @(posedge clk_sys);
    end while (!t);
    sample_valid <= 1'b0;
    adc_overload <= 1'b0;
  endtask : push

  // Three sync pulses, then n samples, then back to idle
  task automatic blk(input int n, input logic [63:0] d, input logic ovl);
    run <= 1'b1;
    want <= want + 4'h3;
    wait_st(5'h08);
    for (int i = 0; i < n; i++)
      push(d + 64'(i), ovl && i == 0);
    wait_st(5'h01);
    run <= 1'b0;
  endtask : blk

  // =====
  // Scenarios
  task automatic t_regs;
    rd(`REG_BLOCK_LEN);
    chk("block_len reset", rv, 32'h0000_0100);
    wr(32'hABCD_0000 | `REG_BLOCK_LEN, 32'h1234_0003);
    rd(`REG_BLOCK_LEN);
    chk("block_len", rv, 32'h0000_0003);
    wr(32'h0000_0040, 32'h0000_0001);
    chk("bresp unmapped", {30'h0, rr}, {30'h0, `RESP_SLVERR});
    rd(32'h0000_0040);
    chk("rresp unmapped", {30'h0, rr}, {30'h0, `RESP_SLVERR});
    $display("test regs done");
  endtask : t_regs

  task automatic t_grant;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk_sys);
      grant_in <= i[3:0];
      @(negedge clk_sys);
      chk("grant_out", {28'h0, grant_out}, {28'h0, i[3:0]});
      chk("bus_request led", {27'h0, led, bus_request}, 32'h0);
    end
    $display("test grant done");
  endtask : t_grant

  task automatic t_vme;
    logic [63:0] w [3];
    w[0] = 64'h1111_2222_3333_4444;
    w[1] = 64'h1111_2222_3333_4445;
    w[2] = {`STATUS_TAG, 48'h0000_0000_0003};
    wr(`REG_CONTROL, 32'h0000_000A);
    wr(`REG_IRQ_ENABLE, 32'h0000_0001);
    wr(`REG_MEAS_CTRL, 32'h0000_0008);
    wr(`REG_BLOCK_LEN, 32'h0000_0002);
    blk(2, w[0], 1'b1);
    @(negedge clk_sys);
    chk("irq", {31'h0, irq}, 32'h1);
    chk("irq_level", {29'h0, irq_level}, 32'h5);
    rd(`REG_IRQ_STATUS);
    chk("irq_status", rv, 32'h0000_000F);
    wr(`REG_IRQ_ENABLE, 32'h0);
    @(negedge clk_sys);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(`REG_IRQ_CLEAR, 32'h0000_000F);
    rd(`REG_IRQ_STATUS);
    chk("irq cleared", rv, 32'h0);
    for (int i = 0; i < 13; i++)
    begin
      rd(`REG_DATA_OUT);
      chk("data_out", rv, (i < 12) ? {16'h0, w[i / 4][16 * (i % 4) +: 16]} : 32'h0);
    end
    $display("test vme done");
  endtask : t_vme

  task automatic t_lbus;
    wr(`REG_PORT_SEL, 32'h0000_0001);
    wr(`REG_MEAS_CTRL, 32'h0);
    wr(`REG_BLOCK_LEN, 32'h0000_0001);
    blk(1, 64'h0123_4567_89AB_CDEF, 1'b0);
    rd(`REG_DATA_OUT);
    chk("data_out lbus", rv, 32'h0);
    for (int i = 0; i < 80 && pbytes !== 4'h8; i++)
      @(posedge clk_sys);
    chk("lbus low", pword[31:0], 32'h89AB_CDEF);
    chk("lbus high", pword[63:32], 32'h0123_4567);
    $display("test lbus done");
  endtask : t_lbus

  task automatic t_drive;
    wr(`REG_MEAS_CTRL, 32'h0000_0007);
    for (int i = 0; i < 40 && sync_line_o !== 1'b1; i++)
      @(negedge clk_sys);
    chk("clk oe", {31'h0, clk_line_oe}, 32'h1);
    chk("sync drive", {30'h0, sync_line_oe, sync_line_o}, 32'h3);
    wr(`REG_MEAS_CTRL, 32'h4);
    for (int i = 0; i < 40 && sync_line_oe !== 1'b0; i++)
      @(negedge clk_sys);
    wr(`REG_MEAS_CTRL, 32'h0);
    chk("released", {30'h0, clk_line_oe, sync_line_oe}, 32'h0);
    $display("test drive done");
  endtask : t_drive

  task automatic t_sysrst;
    wr(`REG_CONTROL, 32'h0000_000E);
    @(posedge clk_sys);
    sysreset_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    sysreset_n <= 1'b1;
    rd(`REG_CONTROL);
    chk("control cleared", rv, 32'h0);
    rd(`REG_IRQ_STATUS);
    chk("status cleared", rv, 32'h0);
    rd(`REG_PORT_SEL);
    chk("port_sel kept", rv, 32'h0000_0001);
    $display("test sysreset done");
  endtask : t_sysrst

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // =====
  // Clock, timeout and main sequence
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      end_of_test();
    end
  end

  initial
  begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, sample_valid, adc_overload, run} = 8'h00;
    {awaddr, wdata, araddr} = 96'h0;
    grant_in = 4'h0;
    want = 4'h0;
    sysreset_n = 1'b1;
    sample_data = 64'h0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_grant();
    t_vme();
    t_lbus();
    t_drive();
    t_sysrst();
    end_of_test();
  end
endmodule : testbench

bind vxi_backplane_slave_port vxi_bp_asserts u_chk (.clk_sys, .rst, .arvalid, .arready, .rdata, .rvalid,
  .rready, .bvalid, .bready, .bresp, .grant_in, .grant_out, .bus_request, .irq, .irq_level, .sysreset_n,
  .reload_config, .lbus_data, .lbus_valid, .lbus_ready);
